// ==== rtl/lsm_pkg.sv ====
/*
  Constants and types shared by the load switch mode controller: timing
  counts, the register map, field positions, reset values and state codes.
  Assumes a 200 MHz core clock and a 32-bit APB register bus.
*/
package lsm_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ           = 200;
  localparam int unsigned STBY_INTERVAL_US  = 10;
  localparam int unsigned RETRY_INTERVAL_US = 2;
  localparam int unsigned STBY_CYCLES       = STBY_INTERVAL_US * CLK_MHZ;
  localparam int unsigned RETRY_CYCLES      = RETRY_INTERVAL_US * CLK_MHZ;

  // ==========================================================================
  // Channels and register map
  // ==========================================================================
  localparam int unsigned NUM_CH       = 2;
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  CTRL_OFF     = 8'h00;
  localparam logic [7:0]  STATUS_OFF   = 8'h04;
  localparam logic [7:0]  IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0]  IRQ_MASK_OFF = 8'h0C;

  localparam int unsigned CTRL_LATCH_BIT = 0;
  localparam logic        CTRL_LATCH_RST = 1'h0;

  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_FAULT_BIT = 0;
  localparam int unsigned IRQ_SLEEP_BIT = 1;
  localparam int unsigned IRQ_UV_BIT    = 2;
  localparam int unsigned IRQ_RETRY_BIT = 3;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_ON_LSB    = 4;
  localparam int unsigned ST_SHUT_LSB  = 8;
  localparam int unsigned ST_FLT_LSB   = 12;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    LSM_SLEEP,
    LSM_ACTIVE,
    LSM_DIAG,
    LSM_FAULT,
    LSM_STBY
  } lsm_state_t;

  typedef enum logic [1:0] {
    LSM_SNS_OFF,
    LSM_SNS_LOAD,
    LSM_SNS_FAULT
  } lsm_sense_t;

endpackage : lsm_pkg

// ==== rtl/lsm_timer.sv ====
/*
  Interval timer: counts while run is high and flags expiry after LIMIT
  cycles of uninterrupted run. Dropping run restarts it from zero.
  Assumes run is synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module lsm_timer #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic clk,     // Core clock.
  input  wire logic rst_b,   // Asynchronous reset, active low.
  input  wire logic run,     // Count while high, clear while low.
  output logic      expired  // High once LIMIT cycles of run have passed.
);

  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= '0;
      expired <= 1'b0;
    end else if (!run) begin
      cnt_r   <= '0;
      expired <= 1'b0;
    end else if (cnt_r == LAST) begin
      expired <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

endmodule : lsm_timer

`default_nettype wire

// ==== rtl/lsm_ctrl.sv ====
/*
  Operating-mode controller of a dual-channel protected load switch: the
  sleep, active, diagnostic, fault and standby-delay state machine, channel
  gating with thermal shutdown and retry, fault flag and sense steering, and
  an APB register slave with a sticky interrupt status.
  Assumes all pin and front-end inputs are synchronous to core_clk.
*/
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RULE1] Sleep shuts all off; any enable wakes
// [RULE2] Sleep goes active on enable, else diagnostic
// [RULE3] Undervoltage forces sleep from every state
// [RULE4] Diagnostic enable enters diagnostic, off-state checks reported
// [RULE5] Flag any channel fault; sense selected only
// [RULE6] Diagnostic low: active if on, else standby
// [RULE7] Any enabled channel on means active state
// [RULE8] Active with diagnostics: sense load until fault
// [RULE9] All off in active: diagnostic or standby
// [RULE10] Fault with enables high enters fault state
// [RULE11] Thermal shutdowns and current limit are faults
// [RULE12] Retry elapsed and cooled: re-enable, leave fault
// [RULE13] Standby keeps rails, sleeps after interval
// [RULE14] Standby: enable to active, diagnostic to diagnostic
// [RULE15] Latching variant needs enable toggle after shutdown
// [RULE16] Absolute shutdown recovers only cooled and timed
// [RULE17] Two channels; interval counters are parameters
// [RULE18] Analog conditions arrive as synchronous status inputs
module lsm_ctrl
  import lsm_pkg::*;
#(
  parameter int unsigned STBY_CNT  = STBY_CYCLES,
  parameter int unsigned RETRY_CNT = RETRY_CYCLES
) (
  input  wire logic              core_clk,            // Core clock, 200 MHz.
  input  wire logic              rst_b,               // Asynchronous reset, active low.
  input  wire logic [ADDR_W-1:0] paddr,               // APB byte address.
  input  wire logic              psel,                // APB select.
  input  wire logic              penable,             // APB enable.
  input  wire logic              pwrite,              // APB direction, high for write.
  input  wire logic [31:0]       pwdata,              // APB write data.
  input  wire logic [3:0]        pstrb,               // APB write byte strobes.
  output logic [31:0]            prdata,              // APB read data.
  output logic                   pready,              // APB ready.
  output logic                   pslverr,             // APB error on unmapped access.
  input  wire logic [NUM_CH-1:0] channel_enable,      // Per-channel enable pins.
  input  wire logic              diagnostic_enable,   // Diagnostic enable pin.
  input  wire logic              channel_select,      // Channel routed to the sense output.
  input  wire logic              supply_undervoltage, // Main supply below its threshold.
  input  wire logic [NUM_CH-1:0] abs_temp_over,       // Junction above limit; see [RULE18].
  input  wire logic [NUM_CH-1:0] abs_temp_cool,       // Junction below limit minus hysteresis.
  input  wire logic [NUM_CH-1:0] rel_temp_over,       // FET-to-controller rise too high.
  input  wire logic [NUM_CH-1:0] current_limit,       // Output held at current limit.
  input  wire logic [NUM_CH-1:0] open_load,           // Off-state open load detected.
  input  wire logic [NUM_CH-1:0] short_to_supply,     // Off-state short to supply detected.
  output logic [NUM_CH-1:0]      channel_on,          // Power FET gate drive per channel.
  output logic                   rails_on,            // Internal rails powered.
  output logic                   fault_flag_n,        // Global fault flag, active low.
  output lsm_sense_t             current_sense_out,   // Sense output mode.
  output logic                   sense_channel,       // Channel shown on the sense output.
  output lsm_state_t             mode,                // Present operating state.
  output logic                   irq                  // Interrupt, active high level.
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  lsm_state_t        state_r;
  lsm_state_t        state_nxt;
  logic [NUM_CH-1:0] shut_r;
  logic [NUM_CH-1:0] abs_shut_r;
  logic [NUM_CH-1:0] ch_fault;
  logic [NUM_CH-1:0] fault_evt;
  logic [NUM_CH-1:0] thermal_evt;
  logic [NUM_CH-1:0] cooled;
  logic              diag_prev_r;
  logic              uv_prev_r;
  logic              latch_mode_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_evt;
  logic [IRQ_W-1:0]  irq_clr;
  logic              any_en;
  logic              diag_rise;
  logic              stby_expired;
  logic              retry_expired;
  logic              retry_fire;
  logic              diag_view;
  logic              setup;
  logic              access;
  logic [31:0]       rd_data;
  logic              rd_err;
  logic              rd_clr_r;

  assign any_en    = |channel_enable;
  assign diag_rise = diagnostic_enable && !diag_prev_r;
  assign mode      = state_r;

  // ==========================================================================
  // Per-channel fault detection
  // ==========================================================================
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign thermal_evt[i] = channel_enable[i] && (abs_temp_over[i] || rel_temp_over[i]);
    assign fault_evt[i]   = thermal_evt[i] || (channel_enable[i] && current_limit[i]); // see [RULE11]
    // A channel shut for absolute overtemperature waits for hysteresis as well.
    assign cooled[i]      = !shut_r[i] || ((!abs_shut_r[i] || abs_temp_cool[i]) && !rel_temp_over[i]); // see [RULE16]
    assign ch_fault[i]    = (state_r == LSM_DIAG) ? (open_load[i] || short_to_supply[i]) // see [RULE4]
                                                  : (shut_r[i] || fault_evt[i]);

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        shut_r[i]     <= 1'b0;
        abs_shut_r[i] <= 1'b0;
      end else if (supply_undervoltage) begin
        shut_r[i]     <= 1'b0;
        abs_shut_r[i] <= 1'b0;
      end else if (thermal_evt[i] && !shut_r[i]) begin
        shut_r[i]     <= 1'b1; // see [RULE11]
        abs_shut_r[i] <= abs_temp_over[i];
      end else if (!channel_enable[i] || retry_fire) begin
        // Dropping the enable always releases; retry only in auto-retry mode.
        shut_r[i]     <= 1'b0; // see [RULE15]
        abs_shut_r[i] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interval timers
  // ==========================================================================
  lsm_timer #(
    .LIMIT (STBY_CNT)
  ) u_stby_timer (
    .clk     (core_clk),
    .rst_b   (rst_b),
    .run     (state_r == LSM_STBY), // see [RULE17]
    .expired (stby_expired)
  );

  lsm_timer #(
    .LIMIT (RETRY_CNT)
  ) u_retry_timer (
    .clk     (core_clk),
    .rst_b   (rst_b),
    .run     ((state_r == LSM_FAULT) && (|shut_r) && !latch_mode_r), // see [RULE17]
    .expired (retry_expired)
  );

  assign retry_fire = retry_expired && (&cooled) && !latch_mode_r && (state_r == LSM_FAULT); // see [RULE12]

  // ==========================================================================
  // Mode state machine
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    if (supply_undervoltage) begin
      state_nxt = LSM_SLEEP; // see [RULE3]
    end else begin
      unique case (state_r)
        LSM_SLEEP: begin
          if (any_en) begin
            state_nxt = LSM_ACTIVE; // see [RULE2]
          end else if (diagnostic_enable) begin
            state_nxt = LSM_DIAG; // see [RULE2]
          end
        end
        LSM_ACTIVE: begin
          if (|fault_evt) begin
            state_nxt = LSM_FAULT; // see [RULE10]
          end else if (!any_en) begin
            state_nxt = diagnostic_enable ? LSM_DIAG : LSM_STBY; // see [RULE9]
          end
        end
        LSM_DIAG: begin
          if (any_en) begin
            state_nxt = LSM_ACTIVE; // see [RULE7]
          end else if (!diagnostic_enable) begin
            state_nxt = LSM_STBY; // see [RULE6]
          end
        end
        LSM_FAULT: begin
          if (!any_en) begin
            state_nxt = diagnostic_enable ? LSM_DIAG : LSM_STBY;
          end else if (!(|shut_r) && !(|fault_evt)) begin
            state_nxt = LSM_ACTIVE; // see [RULE12]
          end
        end
        LSM_STBY: begin
          if (any_en) begin
            state_nxt = LSM_ACTIVE; // see [RULE14]
          end else if (diagnostic_enable || diag_rise) begin
            state_nxt = LSM_DIAG; // see [RULE14]
          end else if (stby_expired) begin
            state_nxt = LSM_SLEEP; // see [RULE13]
          end
        end
        default: begin
          state_nxt = LSM_SLEEP;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= LSM_SLEEP;
      diag_prev_r <= 1'b0;
      uv_prev_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt; // see [RULE4]
      diag_prev_r <= diagnostic_enable;
      uv_prev_r   <= supply_undervoltage;
    end
  end

  // ==========================================================================
  // Pin outputs
  // ==========================================================================
  assign diag_view = diagnostic_enable && (state_r inside {LSM_DIAG, LSM_ACTIVE, LSM_FAULT});

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_on <= '0;
      rails_on   <= 1'b0;
    end else begin
      // Gates follow their own enables only in the switching states.
      channel_on <= ((state_r == LSM_ACTIVE) || (state_r == LSM_FAULT)) && !supply_undervoltage
                    ? (channel_enable & ~shut_r) : '0; // see [RULE7]
      rails_on   <= (state_r != LSM_SLEEP); // see [RULE1] see [RULE13]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_flag_n      <= 1'b1;
      current_sense_out <= LSM_SNS_OFF;
      sense_channel     <= 1'b0;
    end else begin
      fault_flag_n  <= !(diag_view && (|ch_fault)); // see [RULE5] see [RULE8]
      sense_channel <= channel_select;
      if (!diag_view) begin
        current_sense_out <= LSM_SNS_OFF;
      end else if (ch_fault[channel_select]) begin
        current_sense_out <= LSM_SNS_FAULT; // see [RULE5]
      end else if ((state_r != LSM_DIAG) && channel_on[channel_select]) begin
        current_sense_out <= LSM_SNS_LOAD; // see [RULE8]
      end else begin
        current_sense_out <= LSM_SNS_OFF;
      end
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;

  always_comb begin
    rd_data = 32'h0;
    rd_err  = (paddr[1:0] != 2'h0);
    unique case (paddr)
      CTRL_OFF:     rd_data[CTRL_LATCH_BIT] = latch_mode_r;
      STATUS_OFF: begin
        rd_data[ST_STATE_LSB +: 3]     = state_r;
        rd_data[ST_ON_LSB +: NUM_CH]   = channel_on;
        rd_data[ST_SHUT_LSB +: NUM_CH] = shut_r;
        rd_data[ST_FLT_LSB +: NUM_CH]  = ch_fault;
      end
      IRQ_STAT_OFF: rd_data[IRQ_W-1:0] = irq_stat_r;
      IRQ_MASK_OFF: rd_data[IRQ_W-1:0] = irq_mask_r;
      default:      rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      rd_clr_r <= 1'b0;
    end else begin
      pready   <= setup;
      pslverr  <= setup && rd_err;
      prdata   <= (setup && !pwrite && !rd_err) ? rd_data : 32'h0;
      rd_clr_r <= setup && !pwrite && (paddr == IRQ_STAT_OFF);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_mode_r <= CTRL_LATCH_RST;
      irq_mask_r   <= IRQ_MASK_RST;
    end else if (access && pwrite && !pslverr && pstrb[0]) begin
      if (paddr == CTRL_OFF) begin
        latch_mode_r <= pwdata[CTRL_LATCH_BIT]; // see [RULE15]
      end
      if (paddr == IRQ_MASK_OFF) begin
        irq_mask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  assign irq_evt[IRQ_FAULT_BIT] = (state_nxt == LSM_FAULT) && (state_r != LSM_FAULT);
  assign irq_evt[IRQ_SLEEP_BIT] = (state_nxt == LSM_SLEEP) && (state_r != LSM_SLEEP);
  assign irq_evt[IRQ_UV_BIT]    = supply_undervoltage && !uv_prev_r;
  assign irq_evt[IRQ_RETRY_BIT] = retry_fire;
  // Only bits that were returned by the read are cleared.
  assign irq_clr = (access && rd_clr_r) ? prdata[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
      irq <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_mask_r);
    end
  end

endmodule : lsm_ctrl

`default_nettype wire

// ==== tb/lsm_ctrl_assertions.sv ====
/* Concurrent checks on the ports of lsm_ctrl, bound into every instance.
   Assumes one core_clk domain; STBY_CNT matches the bound instance. */
`timescale 1ns/10ps
`default_nettype none

module lsm_ctrl_assertions
  import lsm_pkg::*;
#(
  parameter int unsigned STBY_CNT = STBY_CYCLES
) (
  input wire logic              core_clk,            // Core clock.
  input wire logic              rst_b,               // Reset, active low.
  input wire logic              psel,                // APB select.
  input wire logic              penable,             // APB enable.
  input wire logic              pready,              // APB ready.
  input wire logic [NUM_CH-1:0] channel_enable,      // Enable pins.
  input wire logic              diagnostic_enable,   // Diagnostic enable pin.
  input wire logic              supply_undervoltage, // Supply below threshold.
  input wire logic [NUM_CH-1:0] abs_temp_over,       // Absolute over-temperature.
  input wire logic [NUM_CH-1:0] channel_on,          // Gate drive.
  input wire logic              rails_on,            // Rails powered.
  input wire logic              fault_flag_n,        // Fault flag, active low.
  input wire lsm_state_t        mode                 // Present state.
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  int unsigned stby_run_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stby_run_r <= 0;
    end else begin
      stby_run_r <= (mode == LSM_STBY) ? stby_run_r + 1 : 0;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  chk_uv_sleep: assert property (supply_undervoltage |=> mode == LSM_SLEEP)
    else $error("undervoltage did not force sleep");
  chk_uv_outputs: assert property (supply_undervoltage [*2] |=> channel_on == 2'h0 && !rails_on)
    else $error("outputs alive under undervoltage");
  chk_sleep_dark: assert property (mode == LSM_SLEEP |=> channel_on == 2'h0 && !rails_on)
    else $error("outputs alive in sleep");
  chk_wake_active: assert property (mode == LSM_SLEEP && !supply_undervoltage && |channel_enable
    |=> mode == LSM_ACTIVE)
    else $error("enable did not wake to active");
  chk_wake_diag: assert property (mode == LSM_SLEEP && !supply_undervoltage && channel_enable == 2'h0
    && diagnostic_enable |=> mode == LSM_DIAG)
    else $error("no wake to diagnostic");
  chk_stby_wake: assert property (mode == LSM_STBY && !supply_undervoltage && |channel_enable
    |=> mode == LSM_ACTIVE)
    else $error("no return to active");
  chk_stby_limit: assert property (stby_run_r <= STBY_CNT + 2)
    else $error("standby outlasted its interval");
  chk_active_exit: assert property (mode == LSM_ACTIVE && !supply_undervoltage
    && channel_enable == 2'h0 |=> mode == ($past(diagnostic_enable) ? LSM_DIAG : LSM_STBY))
    else $error("bad state after all off");
  chk_fault_entry: assert property (mode == LSM_ACTIVE && !supply_undervoltage
    && |(channel_enable & abs_temp_over) |=> mode == LSM_FAULT)
    else $error("thermal event did not enter fault");
  chk_fault_cut: assert property (mode == LSM_FAULT && abs_temp_over[0] |=> ##1 !channel_on[0])
    else $error("channel on in shutdown");
  chk_flag_quiet: assert property (!diagnostic_enable [*2] |=> fault_flag_n)
    else $error("fault flag low without diagnostics");
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");

  cov_fault: cover property (mode == LSM_FAULT);
  cov_stby_sleep: cover property (mode == LSM_STBY ##1 mode == LSM_SLEEP);
  cov_diag_flag: cover property (mode == LSM_DIAG && !fault_flag_n);
endmodule : lsm_ctrl_assertions

bind lsm_ctrl lsm_ctrl_assertions #(.STBY_CNT(STBY_CNT)) u_lsm_ctrl_assertions (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
  .channel_enable(channel_enable), .diagnostic_enable(diagnostic_enable),
  .supply_undervoltage(supply_undervoltage), .abs_temp_over(abs_temp_over),
  .channel_on(channel_on), .rails_on(rails_on), .fault_flag_n(fault_flag_n), .mode(mode)
);

`default_nettype wire

// ==== tb/lsm_host.sv ====
/* Host controller model driving the enable, diagnostic and select pins.
   Assumes callers of drive run in one process at a time. */
`timescale 1ns/10ps
`default_nettype none

module lsm_host (
  input  wire logic  core_clk,          // Core clock.
  output var logic [1:0] channel_enable,    // Per-channel enable levels.
  output var logic   diagnostic_enable, // Diagnostic enable level.
  output var logic   channel_select     // Channel chosen for sense.
);
  initial begin
    channel_enable = 2'h0;
    diagnostic_enable = 1'b0;
    channel_select = 1'b0;
  end

  // Pins move just after a rising edge.
  task automatic drive(input logic [1:0] e, input logic d, input logic s);
    @(posedge core_clk);
    channel_enable <= e;
    diagnostic_enable <= d;
    channel_select <= s;
  endtask : drive
endmodule : lsm_host

`default_nettype wire

// ==== tb/lsm_ctrl_test.sv ====
/* Bench for lsm_ctrl: APB and pin tasks, mode scenarios and the verdict.
   Assumes lsm_host drives the host pins and the checker is bound. */
`timescale 1ns/10ps
`default_nettype none

module lsm_ctrl_test
  import lsm_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  localparam int STBY  = 8;
  localparam int RETRY = 5;
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic        uv       = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [11:0] fe       = 12'h300;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, rails_on, fault_flag_n, sense_channel, irq, diag, sel;
  logic [1:0]  en, chan_on;
  lsm_sense_t  sense;
  lsm_state_t  mode;
  int          miscompares = 0;
  int          n_checks    = 0;

  always #2.5 core_clk = ~core_clk;

  lsm_host u_lsm_host (.core_clk(core_clk), .channel_enable(en), .diagnostic_enable(diag), .channel_select(sel));
  lsm_ctrl #(.STBY_CNT(STBY), .RETRY_CNT(RETRY)) u_lsm_ctrl (
    .core_clk(core_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_enable(en), .diagnostic_enable(diag), .channel_select(sel),
    .supply_undervoltage(uv), .abs_temp_over(fe[11:10]), .abs_temp_cool(fe[9:8]),
    .rel_temp_over(fe[7:6]), .current_limit(fe[5:4]), .open_load(fe[3:2]),
    .short_to_supply(fe[1:0]), .channel_on(chan_on), .rails_on(rails_on),
    .fault_flag_n(fault_flag_n), .current_sense_out(sense), .sense_channel(sense_channel),
    .mode(mode), .irq(irq)
  );

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pins(input logic [1:0] e, input logic d, input logic s);
    u_lsm_host.drive(e, d, s);
    tick(3);
  endtask : pins

  // Front-end bits: over, cool, rel, limit, open, short.
  task automatic front(input logic [11:0] v, input int n);
    @(posedge core_clk);
    fe <= v;
    tick(n);
  endtask : front

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    report_and_stop;
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    tick(1);
    chk({mode, rails_on, fault_flag_n, chan_on}, {LSM_SLEEP, 4'h4});
    apb(1'b0, CTRL_OFF, 32'h0);
    chk({err, rd}, {1'b0, 31'h0, CTRL_LATCH_RST});
    apb(1'b0, IRQ_MASK_OFF, 32'h0);
    chk({err, rd}, {1'b0, 28'h0, IRQ_MASK_RST});
    apb(1'b1, IRQ_MASK_OFF, 32'hFFFF_FFFF);
    apb(1'b0, IRQ_MASK_OFF, 32'h0);
    chk(rd, 32'h0000_000F);
    apb(1'b1, STATUS_OFF, 32'h0000_3FFF);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk({err, rd}, 36'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b0, IRQ_STAT_OFF, 32'h0);
    apb(1'b1, IRQ_MASK_OFF, 32'h1 << IRQ_SLEEP_BIT);
    pins(2'h0, 1'b1, 1'b1);
    chk(mode, LSM_DIAG);
    front(12'h308, 3);
    chk({fault_flag_n, sense, sense_channel}, {1'b0, LSM_SNS_FAULT, 1'b1});
    pins(2'h0, 1'b1, 1'b0);
    chk({fault_flag_n, sense}, {1'b0, LSM_SNS_OFF});
    front(12'h301, 3);
    chk(sense, LSM_SNS_FAULT);
    front(12'h300, 1);
    pins(2'h0, 1'b0, 1'b0);
    chk({mode, rails_on}, {LSM_STBY, 1'b1});
    tick(STBY + 4);
    chk({mode, rails_on, irq}, {LSM_SLEEP, 1'b0, 1'b1});
    apb(1'b0, IRQ_STAT_OFF, 32'h0);
    chk(rd[IRQ_SLEEP_BIT], 1'b1);
    tick(2);
    chk(irq, 1'b0);
    pins(2'h1, 1'b0, 1'b0);
    chk({mode, rails_on, chan_on}, {LSM_ACTIVE, 1'b1, 2'h1});
    pins(2'h0, 1'b0, 1'b0);
    chk({mode, chan_on}, {LSM_STBY, 2'h0});
    pins(2'h2, 1'b0, 1'b0);
    chk({mode, rails_on, chan_on}, {LSM_ACTIVE, 1'b1, 2'h2});
    pins(2'h0, 1'b1, 1'b0);
    chk(mode, LSM_DIAG);
    pins(2'h0, 1'b0, 1'b0);
    pins(2'h0, 1'b1, 1'b0);
    chk(mode, LSM_DIAG);
    pins(2'h3, 1'b1, 1'b0);
    chk({mode, chan_on, sense, fault_flag_n}, {LSM_ACTIVE, 2'h3, LSM_SNS_LOAD, 1'b1});
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(rd, (32'(LSM_ACTIVE) << ST_STATE_LSB) | (32'h3 << ST_ON_LSB));
    for (int k = 0; k < 3; k++) begin
      front(k == 0 ? 12'h700 : k == 1 ? 12'h340 : 12'h310, 3);
      chk({mode, fault_flag_n, sense}, {LSM_FAULT, 1'b0, LSM_SNS_FAULT});
      if (k < 2) chk(chan_on, 2'h2);
      front(12'h300, RETRY + 8);
      chk({mode, chan_on}, {LSM_ACTIVE, 2'h3});
    end
    chk(irq, 1'b0);
    apb(1'b0, IRQ_STAT_OFF, 32'h0);
    chk({rd[IRQ_RETRY_BIT], rd[IRQ_FAULT_BIT]}, 2'h3);
    front(12'h400, 2);
    front(12'h000, RETRY + 8);
    chk({mode, chan_on}, {LSM_FAULT, 2'h2});
    front(12'h300, 4);
    chk({mode, chan_on}, {LSM_ACTIVE, 2'h3});
    apb(1'b1, CTRL_OFF, 32'h1);
    front(12'h700, 2);
    front(12'h300, RETRY + 8);
    chk({mode, chan_on}, {LSM_FAULT, 2'h2});
    pins(2'h2, 1'b1, 1'b0);
    pins(2'h3, 1'b1, 1'b0);
    chk({mode, chan_on}, {LSM_ACTIVE, 2'h3});
    apb(1'b1, CTRL_OFF, 32'h0);
    @(posedge core_clk);
    uv <= 1'b1;
    tick(3);
    chk({mode, rails_on, chan_on}, {LSM_SLEEP, 1'b0, 2'h0});
    @(posedge core_clk);
    uv <= 1'b0;
    tick(3);
    chk(mode, LSM_ACTIVE);
    report_and_stop;
  end
endmodule : lsm_ctrl_test

`default_nettype wire
